// File: logic/fanlut_map.svh
// How it works
// R1: table writes only when 4A bit5 set
// R2: low-res temperature reads bit 7 as zero
// R3: high-res limit is half-degree, 0 to 127.5
// R4: low-res limit is whole degrees, 0 to 127
// R5: compare 9 reading bits high, 8 low
// R6: limit sign bit is always zero
// R7: software uses offset register above 127
// R8: above entry ten limit, drive duty ten
// R9: above entry eleven limit, drive duty eleven
// R10: low-res duty reads bits 7:6 as zero
// R11: high-res duty uses all eight bits
// R12: extended duty bits need 22.5kHz selected
// R13: low-res duty ten uses bits 5:0
// R14: low-res duty nine uses bits 5:0
// R15: locked writes leave table unchanged
`ifndef FANLUT_MAP_SVH
`define FANLUT_MAP_SVH

// register indices; byte address is four times the index
`define FL_IDX_CTRL   8'h4A
`define FL_IDX_D9     8'h61
`define FL_IDX_T10    8'h62
`define FL_IDX_D10    8'h63
`define FL_IDX_T11    8'h64
`define FL_IDX_MODE   8'h70
`define FL_IDX_STAT   8'h71

// field positions
`define FL_CTRL_WEN_BIT  5
`define FL_MODE_THI_BIT  0
`define FL_MODE_DHI_BIT  1
`define FL_MODE_F22_BIT  2

// reset values
`define FL_RST_TEMP   8'h7F
`define FL_RST_DUTY   8'h3F
`define FL_RST_CTRL   8'h00
`define FL_RST_MODE   8'h00

`endif

// File: logic/fanlut_pkg.sv
package fanlut_pkg;
   // one register byte of the table
   typedef logic [7:0]  fanlut_byte_t;
   // remote reading, unsigned, eighth-degree steps
   typedef logic [10:0] fanlut_rtemp_t;
   // which entry currently drives the duty output
   typedef enum logic [1:0] {
      FANLUT_SEL_BELOW,
      FANLUT_SEL_NINE,
      FANLUT_SEL_TEN,
      FANLUT_SEL_ELEVEN
   } fanlut_sel_t;
endpackage : fanlut_pkg

// File: logic/fanlut_if.sv
`timescale 1ns/1ps
`default_nettype none
// mode bits and reading shared by every table entry
interface fanlut_if;
   import fanlut_pkg::*;
   logic          temp_hi_res;   // half-degree limits
   logic          duty_hi_res;   // eight-bit duties
   logic          freq_22k;      // 22.5kHz output selected
   fanlut_rtemp_t remote_temp;   // latest remote reading
   modport ctl (output temp_hi_res, duty_hi_res, freq_22k, remote_temp);
   modport ent (input temp_hi_res, duty_hi_res, freq_22k, remote_temp);
endinterface : fanlut_if
`default_nettype wire

// File: logic/fanlut_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// one entry's limit test against the remote reading
module fanlut_cmp
   import fanlut_pkg::*;
(
   fanlut_if.ent        lk,
   input  wire fanlut_byte_t limit,
   output logic         over
);
   logic [8:0] rd9_w;   // whole degrees plus half bit
   logic [8:0] lim9_w;  // half-degree limit, sign forced low
   logic [7:0] rd8_w;   // whole degrees only
   logic [7:0] lim8_w;  // whole-degree limit, sign forced low
   logic       hi_w;    // strict compare, high resolution
   logic       lo_w;    // strict compare, low resolution

   // reading keeps eighth-degree bits; the low ones are dropped
   assign rd9_w  = lk.remote_temp[10:2];                      // R5
   assign rd8_w  = lk.remote_temp[10:3];                      // R5
   assign lim9_w = {1'b0, limit[6:0], limit[7]};              // R3 R6
   assign lim8_w = {1'b0, limit[6:0]};                        // R4 R6
   assign hi_w   = rd9_w > lim9_w;
   assign lo_w   = rd8_w > lim8_w;
   // only exceeding counts; equal stays in the lower entry
   assign over   = lk.temp_hi_res ? hi_w : lo_w;
endmodule : fanlut_cmp
`default_nettype wire

// File: logic/fanlut_duty.sv
`timescale 1ns/1ps
`default_nettype none
// turns a stored duty byte into the value that drives output
module fanlut_duty
   import fanlut_pkg::*;
(
   fanlut_if.ent        lk,
   input  wire fanlut_byte_t raw,
   output fanlut_byte_t eff
);
   logic ext_ok_w;   // extended bits allowed to act

   // extended bits need both the mode and the 22.5kHz rate
   assign ext_ok_w = lk.duty_hi_res & lk.freq_22k;            // R12
   assign eff      = ext_ok_w ? raw                           // R11
                              : {2'b00, raw[5:0]};            // R13 R14
endmodule : fanlut_duty
`default_nettype wire

// File: logic/fanlut_top.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "fanlut_map.svh"
// lookup table entries nine to eleven with an avalon slave
module fanlut_top
   import fanlut_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          reset_n,
   input  wire logic [7:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest,
   input  wire fanlut_rtemp_t remote_temp,
   input  wire fanlut_byte_t  lut_temp_limit_nine,
   input  wire fanlut_byte_t  lut_duty_eleven,
   input  wire fanlut_byte_t  duty_below,
   output fanlut_byte_t       pwm_duty,
   output fanlut_sel_t        duty_sel
);
   // software registers
   fanlut_byte_t ctrl_r;                  // write-enable control
   fanlut_byte_t mode_r;                  // resolution and rate
   fanlut_byte_t lut_duty_nine_r;         // entry nine duty
   fanlut_byte_t lut_temp_limit_ten_r;    // entry ten limit
   fanlut_byte_t lut_duty_ten_r;          // entry ten duty
   fanlut_byte_t lut_temp_limit_eleven_r; // entry eleven limit

   // bus state
   logic         wait_r;      // waitrequest flop
   logic [31:0]  rdata_r;     // read data flop
   fanlut_byte_t pwm_duty_r;  // driven duty
   fanlut_sel_t  sel_r;       // driving entry

   // decode
   logic req_w;        // any request pending
   logic wr_go_w;      // write committed this edge
   logic rd_load_w;    // read data loaded this edge
   logic wen_w;        // table unlocked
   logic hit_ctrl_w;
   logic hit_mode_w;
   logic hit_d9_w;
   logic hit_t10_w;
   logic hit_d10_w;
   logic hit_t11_w;
   logic hit_stat_w;
   logic tbl_wr_w;     // table write allowed

   // read view
   fanlut_byte_t rd_t10_w;
   fanlut_byte_t rd_t11_w;
   fanlut_byte_t rd_d9_w;
   fanlut_byte_t rd_d10_w;
   logic [31:0]  rd_mux_w;

   // per-entry results, index 0 is entry nine
   fanlut_byte_t lim_w  [3];
   fanlut_byte_t raw_w  [3];
   fanlut_byte_t eff_w  [3];
   logic [2:0]   over_w;
   fanlut_byte_t duty_nxt;
   fanlut_sel_t  sel_nxt;

   fanlut_if lk ();

   // mode bits and reading shared by the entries
   assign lk.temp_hi_res = mode_r[`FL_MODE_THI_BIT];
   assign lk.duty_hi_res = mode_r[`FL_MODE_DHI_BIT];
   assign lk.freq_22k    = mode_r[`FL_MODE_F22_BIT];
   assign lk.remote_temp = remote_temp;

   // one wait cycle per request: answer on the second edge
   assign req_w     = avs_read | avs_write;
   assign wr_go_w   = avs_write & ~wait_r;
   assign rd_load_w = avs_read & wait_r;
   assign wen_w     = ctrl_r[`FL_CTRL_WEN_BIT];

   // address decode on the word index
   assign hit_ctrl_w = avs_address == `FL_IDX_CTRL;
   assign hit_mode_w = avs_address == `FL_IDX_MODE;
   assign hit_d9_w   = avs_address == `FL_IDX_D9;
   assign hit_t10_w  = avs_address == `FL_IDX_T10;
   assign hit_d10_w  = avs_address == `FL_IDX_D10;
   assign hit_t11_w  = avs_address == `FL_IDX_T11;
   assign hit_stat_w = avs_address == `FL_IDX_STAT;

   // table entries accept data only while unlocked
   assign tbl_wr_w = wr_go_w & wen_w;                         // R1 R15

   // low resolution hides the unused upper bits on read
   assign rd_t10_w = lk.temp_hi_res ? lut_temp_limit_ten_r
                   : {1'b0, lut_temp_limit_ten_r[6:0]};       // R2
   assign rd_t11_w = lk.temp_hi_res ? lut_temp_limit_eleven_r
                   : {1'b0, lut_temp_limit_eleven_r[6:0]};    // R2
   assign rd_d9_w  = lk.duty_hi_res ? lut_duty_nine_r
                   : {2'b00, lut_duty_nine_r[5:0]};           // R10
   assign rd_d10_w = lk.duty_hi_res ? lut_duty_ten_r
                   : {2'b00, lut_duty_ten_r[5:0]};            // R10

   // reads are always allowed; unmapped indices read zero
   assign rd_mux_w =
      hit_ctrl_w ? {24'h000000, ctrl_r} :
      hit_mode_w ? {24'h000000, mode_r} :
      hit_d9_w   ? {24'h000000, rd_d9_w} :                    // R1
      hit_t10_w  ? {24'h000000, rd_t10_w} :
      hit_d10_w  ? {24'h000000, rd_d10_w} :
      hit_t11_w  ? {24'h000000, rd_t11_w} :
      hit_stat_w ? {22'h0, sel_r, pwm_duty_r} :
                   32'h00000000;

   // the three entries in one loop
   assign lim_w[0] = lut_temp_limit_nine;
   assign lim_w[1] = lut_temp_limit_ten_r;
   assign lim_w[2] = lut_temp_limit_eleven_r;
   assign raw_w[0] = lut_duty_nine_r;
   assign raw_w[1] = lut_duty_ten_r;
   assign raw_w[2] = lut_duty_eleven;

   generate
      for (genvar e = 0; e < 3; e++)
      begin : g_entry
         fanlut_cmp u_cmp (
            .lk    (lk),
            .limit (lim_w[e]),
            .over  (over_w[e])
         );
         fanlut_duty u_duty (
            .lk  (lk),
            .raw (raw_w[e]),
            .eff (eff_w[e])
         );
      end
   endgenerate

   // highest exceeded entry wins; else lower entries decide
   assign duty_nxt = over_w[2] ? eff_w[2] :                   // R9
                     over_w[1] ? eff_w[1] :                   // R8
                     over_w[0] ? eff_w[0] : duty_below;
   assign sel_nxt  = over_w[2] ? FANLUT_SEL_ELEVEN :
                     over_w[1] ? FANLUT_SEL_TEN :
                     over_w[0] ? FANLUT_SEL_NINE : FANLUT_SEL_BELOW;

   // bus handshake: wait high at rest, low for one answer cycle
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h00000000;
      end
      else
      begin
         wait_r <= ~(req_w & wait_r);
         if (rd_load_w)
            rdata_r <= rd_mux_w;
      end
   end

   // control and mode are never locked, so software can unlock
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         ctrl_r <= `FL_RST_CTRL;
         mode_r <= `FL_RST_MODE;
      end
      else
      begin
         if (wr_go_w && hit_ctrl_w)
            ctrl_r <= avs_writedata[7:0];
         if (wr_go_w && hit_mode_w)
            mode_r <= avs_writedata[7:0];
      end
   end

   // table registers; full byte stored, masking is on read
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         lut_duty_nine_r         <= `FL_RST_DUTY;
         lut_temp_limit_ten_r    <= `FL_RST_TEMP;
         lut_duty_ten_r          <= `FL_RST_DUTY;
         lut_temp_limit_eleven_r <= `FL_RST_TEMP;
      end
      else if (tbl_wr_w)                                      // R1 R15
      begin
         if (hit_d9_w)
            lut_duty_nine_r <= avs_writedata[7:0];
         if (hit_t10_w)
            lut_temp_limit_ten_r <= avs_writedata[7:0];
         if (hit_d10_w)
            lut_duty_ten_r <= avs_writedata[7:0];
         if (hit_t11_w)
            lut_temp_limit_eleven_r <= avs_writedata[7:0];
      end
   end

   // output duty registered, one cycle after the compare
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         pwm_duty_r <= 8'h00;
         sel_r      <= FANLUT_SEL_BELOW;
      end
      else
      begin
         pwm_duty_r <= duty_nxt;                              // R8 R9
         sel_r      <= sel_nxt;
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;
   assign pwm_duty        = pwm_duty_r;
   assign duty_sel        = sel_r;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   wait_answer_a: assert property (                           // R1
      req_w && wait_r |=> !wait_r)
      else $error("request not answered after one wait");

   lock_hold_a: assert property (                             // R15
      wr_go_w && !wen_w && hit_t10_w
      |=> lut_temp_limit_ten_r == $past(lut_temp_limit_ten_r))
      else $error("locked write changed entry ten limit");

   unlock_store_a: assert property (                          // R1
      wr_go_w && wen_w && hit_d10_w
      |=> lut_duty_ten_r == $past(avs_writedata[7:0]))
      else $error("unlocked write not stored");

   temp_mask_a: assert property (                             // R2
      avs_read && !wait_r && hit_t10_w && !lk.temp_hi_res
      && $stable(mode_r) |-> avs_readdata[7] == 1'b0)
      else $error("low-res temperature read shows bit 7");

   duty_mask_a: assert property (                             // R10
      avs_read && !wait_r && hit_d10_w && !lk.duty_hi_res
      && $stable(mode_r) |-> avs_readdata[7:6] == 2'b00)
      else $error("low-res duty read shows bits 7:6");

   hires_cmp_a: assert property (                             // R3
      lk.temp_hi_res && remote_temp[10:2] >
      {1'b0, lut_temp_limit_ten_r[6:0], lut_temp_limit_ten_r[7]}
      |-> over_w[1])
      else $error("half-degree compare missed");

   lowres_cmp_a: assert property (                            // R4
      !lk.temp_hi_res
      && remote_temp[10:3] <= {1'b0, lut_temp_limit_ten_r[6:0]}
      |-> !over_w[1])
      else $error("low-res compare fired too early");

   ten_drive_a: assert property (                             // R8
      over_w[1] && !over_w[2] && lk.duty_hi_res && lk.freq_22k
      |=> pwm_duty_r == $past(lut_duty_ten_r)
          && sel_r == FANLUT_SEL_TEN)
      else $error("entry ten duty not driven");

   eleven_drive_a: assert property (                          // R9
      over_w[2]
      |=> sel_r == FANLUT_SEL_ELEVEN
          && pwm_duty_r[5:0] == $past(lut_duty_eleven[5:0])
          && pwm_duty_r[7:6] == ($past(lk.duty_hi_res && lk.freq_22k)
                                 ? $past(lut_duty_eleven[7:6]) : 2'b00))
      else $error("entry eleven duty not driven");

   ext_gate_a: assert property (                              // R12
      over_w[1] && !over_w[2] && !lk.freq_22k
      |=> pwm_duty_r == {2'b00, $past(lut_duty_ten_r[5:0])})
      else $error("extended duty bits acted off 22.5kHz");

   nine_low_a: assert property (                              // R14
      over_w == 3'b001 && !lk.duty_hi_res
      |=> pwm_duty_r == {2'b00, $past(lut_duty_nine_r[5:0])})
      else $error("entry nine low-res duty wrong");

   ten_low_a: assert property (                               // R13
      over_w[1] && !over_w[2] && !lk.duty_hi_res
      |=> pwm_duty_r[5:0] == $past(lut_duty_ten_r[5:0]))
      else $error("entry ten low-res duty wrong");

   // entry eleven limit shares the low-res read mask
   eleven_mask_a: assert property (                           // R2
      avs_read && !wait_r && hit_t11_w && !lk.temp_hi_res
      && $stable(mode_r) |-> avs_readdata[7] == 1'b0)
      else $error("low-res entry eleven read shows bit 7");

   // entry nine duty shares the low-res read mask
   nine_mask_a: assert property (                             // R10
      avs_read && !wait_r && hit_d9_w && !lk.duty_hi_res
      && $stable(mode_r) |-> avs_readdata[7:6] == 2'b00)
      else $error("low-res entry nine duty shows bits 7:6");

   // software may sample read data late, so it must not drift
   rdata_hold_a: assert property (                            // R1
      !rd_load_w |=> $stable(avs_readdata))
      else $error("read data moved without a read");

   locked_wr_c: cover property (wr_go_w && !wen_w && hit_t10_w);
   unlocked_wr_c: cover property (tbl_wr_w && hit_t11_w);
   eleven_sel_c: cover property (over_w[2] ##1 sel_r == FANLUT_SEL_ELEVEN);
   hires_duty_c: cover property (lk.duty_hi_res && lk.freq_22k && over_w[1]);
   nine_sel_c: cover property (over_w == 3'b001 ##1 sel_r == FANLUT_SEL_NINE);
endmodule : fanlut_top
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fanlut_map.svh"
// register bank and duty path of table entries nine to eleven
module tb_top
   import fanlut_pkg::*;
;
   logic          mclk;             // 125 MHz clock
   logic          reset_n;          // synchronous reset, active low
   logic [7:0]    avs_address;      // word index
   logic          avs_read;         // read strobe
   logic          avs_write;        // write strobe
   logic [31:0]   avs_writedata;    // write data
   logic [31:0]   avs_readdata;     // read data
   logic          avs_waitrequest;  // slave stall
   fanlut_rtemp_t remote_temp;      // remote reading
   fanlut_byte_t  limit_nine;       // neighbouring entry nine limit
   fanlut_byte_t  duty_eleven;      // neighbouring entry eleven duty
   fanlut_byte_t  duty_below;       // duty of the lower entries
   fanlut_byte_t  pwm_duty;         // selected duty
   fanlut_sel_t   duty_sel;         // selected entry
   int            err_count;        // mismatches seen
   int            comparisons;      // checks made
   fanlut_top fanlut_top_i (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .remote_temp(remote_temp), .lut_temp_limit_nine(limit_nine),
      .lut_duty_eleven(duty_eleven), .duty_below(duty_below), .pwm_duty(pwm_duty),
      .duty_sel(duty_sel));
   // free running clock, half period 4 ns
   always #4 mclk = ~mclk;
   // one place ends the run
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   // compares a seen value against the expected one
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one bus cycle; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
      int n;
      @(posedge mclk);
      avs_address   <= idx;
      avs_writedata <= {24'h000000, wd};
      avs_write     <= wr;
      avs_read      <= ~wr;
      for (n = 0; n < 20; n++)
      begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      // a stuck slave ends the run rather than hanging it
      if (n == 20)
      begin
         err_count++;
         give_verdict();
      end
   endtask : bus
   // write one register byte
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
      logic [31:0] dummy;
      bus(1'b1, idx, wd, dummy);
   endtask : wr_reg
   // read one register and compare it
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, idx, 8'h00, rd);
      check($sformatf("reg %h", idx), rd, exp);
   endtask : rd_chk
   // apply a reading, let the one-edge path settle, then judge it
   task automatic see_duty(input fanlut_rtemp_t t, input fanlut_byte_t ed, input fanlut_sel_t es);
      remote_temp <= t;
      repeat (3) @(posedge mclk);
      check("pwm_duty", {24'h000000, pwm_duty}, {24'h000000, ed});
      check("duty_sel", {30'h0, duty_sel}, {30'h0, es});
   endtask : see_duty
   // reset values, then writes while the table is locked
   task automatic t_locked();
      rd_chk(`FL_IDX_CTRL, 32'h00000000);
      rd_chk(`FL_IDX_T10, 32'h0000007F);
      rd_chk(`FL_IDX_D10, 32'h0000003F);
      rd_chk(`FL_IDX_T11, 32'h0000007F);
      rd_chk(`FL_IDX_D9, 32'h0000003F);
      wr_reg(`FL_IDX_T11, 8'h10);
      wr_reg(`FL_IDX_D10, 8'h01);
      wr_reg(`FL_IDX_T10, 8'h44);
      rd_chk(`FL_IDX_T11, 32'h0000007F);
      rd_chk(`FL_IDX_D10, 32'h0000003F);
      rd_chk(`FL_IDX_T10, 32'h0000007F);
      // unmapped place: write dropped, read gives zero
      wr_reg(8'h00, 8'hA5);
      rd_chk(8'h00, 32'h00000000);
      $display("test locked done");
   endtask : t_locked
   // unlocked writes and low resolution read masking
   task automatic t_fields();
      wr_reg(`FL_IDX_CTRL, 8'h20);
      wr_reg(`FL_IDX_T10, 8'hB2);
      wr_reg(`FL_IDX_D10, 8'hE5);
      wr_reg(`FL_IDX_D9, 8'hE9);
      wr_reg(`FL_IDX_T11, 8'hBC);
      rd_chk(`FL_IDX_T10, 32'h00000032);
      rd_chk(`FL_IDX_D10, 32'h00000025);
      rd_chk(`FL_IDX_T11, 32'h0000003C);
      rd_chk(`FL_IDX_D9, 32'h00000029);
      wr_reg(`FL_IDX_MODE, 8'h07);
      rd_chk(`FL_IDX_T10, 32'h000000B2);
      rd_chk(`FL_IDX_D10, 32'h000000E5);
      rd_chk(`FL_IDX_T11, 32'h000000BC);
      rd_chk(`FL_IDX_D9, 32'h000000E9);
      wr_reg(`FL_IDX_MODE, 8'h00);
      $display("test fields done");
   endtask : t_fields
   // entry selection in low resolution, strict greater, highest wins
   task automatic t_select_low();
      see_duty(11'h0F0, 8'h11, FANLUT_SEL_BELOW);
      see_duty(11'h168, 8'h29, FANLUT_SEL_NINE);
      see_duty(11'h194, 8'h29, FANLUT_SEL_NINE);
      wr_reg(`FL_IDX_T10, 8'h32);
      see_duty(11'h190, 8'h29, FANLUT_SEL_NINE);
      see_duty(11'h198, 8'h25, FANLUT_SEL_TEN);
      see_duty(11'h1E8, 8'h1A, FANLUT_SEL_ELEVEN);
      $display("test select low done");
   endtask : t_select_low
   // half degree limits compare nine reading bits
   task automatic t_select_high();
      wr_reg(`FL_IDX_MODE, 8'h01);
      see_duty(11'h194, 8'h25, FANLUT_SEL_TEN);
      wr_reg(`FL_IDX_T10, 8'hB2);
      see_duty(11'h196, 8'h29, FANLUT_SEL_NINE);
      see_duty(11'h198, 8'h25, FANLUT_SEL_TEN);
      $display("test select high done");
   endtask : t_select_high
   // extended duty bits need both duty mode and the fast frequency
   task automatic t_duty_ext();
      wr_reg(`FL_IDX_MODE, 8'h03);
      see_duty(11'h198, 8'h25, FANLUT_SEL_TEN);
      wr_reg(`FL_IDX_MODE, 8'h07);
      see_duty(11'h198, 8'hE5, FANLUT_SEL_TEN);
      rd_chk(`FL_IDX_STAT, 32'h000002E5);
      see_duty(11'h1E8, 8'hDA, FANLUT_SEL_ELEVEN);
      $display("test duty ext done");
   endtask : t_duty_ext
   // main sequence
   initial
   begin
      mclk          = 1'b0;
      reset_n       = 1'b0;
      avs_address   = 8'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h00000000;
      remote_temp   = 11'h000;
      limit_nine    = 8'h28;
      duty_eleven   = 8'hDA;
      duty_below    = 8'h11;
      err_count     = 0;
      comparisons   = 0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      t_locked();
      t_fields();
      t_select_low();
      t_select_high();
      t_duty_ext();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
